/* core/cc_map.vh */
// Field positions, reset value and timing counts of the cache control register.
`ifndef CC_MAP_VH
`define CC_MAP_VH
`define CC_ENB_BIT 31
`define CC_INV_ALL_BIT 24
`define CC_INSTR_OFF_BIT 23
`define CC_DATA_OFF_BIT 22
`define CC_INV_INSTR_BIT 21
`define CC_INV_DATA_BIT 20
`define CC_RSVD_HI 19
`define CC_RSVD_LO 11
`define CC_NC_BURST_BIT 10
`define CC_DEF_CACHE_OFF_BIT 9
`define CC_DEF_WBUF_BIT 8
`define CC_FILL_HI 1
`define CC_FILL_LO 0
`define CC_RESET_VALUE 32'h00000000
`define CC_WRITE_MASK 32'h80F00703
`define CC_TAG_ENTRIES 512
`define CC_TAG_HALF 256
`define CC_INV_OVERHEAD 3
`endif

/* core/cc_ctrl.v */
// Cache control register with invalidate-all engine, configuration decode and write-buffer policy.
`timescale 1ns/1ps
`default_nettype none
`include "cc_map.vh"
module cc_ctrl #(
    parameter TAG_ENTRIES = `CC_TAG_ENTRIES,
    parameter TAG_HALF = `CC_TAG_HALF,
    parameter INV_OVERHEAD = `CC_INV_OVERHEAD,
    parameter IDX_W = 9
) (
    // Clock and reset.
    input wire mclk,
    input wire rst_n,
    // Supervisor control-register write from the core.
    input wire ctl_wr_en,
    input wire ctl_supervisor,
    input wire [31:0] ctl_wr_data,
    // Debug read of the control register.
    output wire [31:0] ctl_rd_data,
    // Tag array clear port.
    output reg tag_clr_en_reg,
    output reg [IDX_W-1:0] tag_clr_idx_reg,
    output wire inv_busy,
    // Cache configuration.
    output wire cfg_array_on,
    output wire cfg_split,
    output wire cfg_instr_cache,
    output wire cfg_data_cache,
    // Default attributes and line fill.
    input wire acc_default_attr,
    input wire acc_map_cacheable,
    output wire acc_cacheable,
    input wire fill_noncacheable,
    output wire fill_burst,
    output wire [1:0] fill_size,
    input wire lfb_write_req,
    input wire lfb_noncacheable,
    output wire array_write_en,
    // Local-bus operand writes and bus controller.
    input wire lb_wr_req,
    output wire lb_wr_term,
    output wire bc_wr_push,
    output wire bc_wr_buffered,
    input wire ext_wr_done,
    input wire ext_wr_err,
    output reg wr_access_err_reg
);

    localparam ST_IDLE = 2'h0;
    localparam ST_OVH = 2'h1;
    localparam ST_CLR = 2'h2;

    reg [31:0] ctl_reg;
    reg [31:0] ctl_next;
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [IDX_W-1:0] idx_next;
    reg [IDX_W-1:0] last_reg;
    reg [IDX_W-1:0] last_next;
    reg [IDX_W:0] ovh_reg;
    reg [IDX_W:0] ovh_next;
    reg clr_next;
    reg wait_reg;
    reg wait_next;
    reg inv_go;
    reg inv_none;
    reg [IDX_W-1:0] inv_first;
    reg [IDX_W-1:0] inv_last;

    wire wr_ok = ctl_wr_en & ctl_supervisor;
    wire new_instr_off = ctl_wr_data[`CC_INSTR_OFF_BIT];
    wire new_data_off = ctl_wr_data[`CC_DATA_OFF_BIT];
    wire new_split = ~new_instr_off & ~new_data_off;
    wire instr_off = ctl_reg[`CC_INSTR_OFF_BIT];
    wire data_off = ctl_reg[`CC_DATA_OFF_BIT];
    wire inv_instr_only = ctl_reg[`CC_INV_INSTR_BIT];
    wire inv_data_only = ctl_reg[`CC_INV_DATA_BIT];

    // Parameter-sized constants, cut to the index width on purpose.
    wire [31:0] full_last_w = TAG_ENTRIES - 1;
    wire [31:0] half_first_w = TAG_HALF;
    wire [31:0] half_last_w = TAG_HALF - 1;
    wire [31:0] ovh_init_w = INV_OVERHEAD - 1;

    // Register write; the selective-invalidate bits only stick in split form.
    always @* begin
        ctl_next = ctl_reg;
        if (wr_ok) begin
            ctl_next = ctl_wr_data & `CC_WRITE_MASK;
            if (!new_split) begin
                ctl_next[`CC_INV_INSTR_BIT] = 1'b0;
                ctl_next[`CC_INV_DATA_BIT] = 1'b0;
            end
        end
    end

    // The invalidate-all bit is never stored, so it always reads back as zero.
    // Reserved and unimplemented positions are tied low instead of read from storage.
    assign ctl_rd_data = {
        ctl_reg[`CC_ENB_BIT],
        6'h00,
        1'h0,
        instr_off,
        data_off,
        inv_instr_only,
        inv_data_only,
        9'h000,
        ctl_reg[`CC_NC_BURST_BIT],
        ctl_reg[`CC_DEF_CACHE_OFF_BIT],
        ctl_reg[`CC_DEF_WBUF_BIT],
        6'h00,
        ctl_reg[`CC_FILL_HI:`CC_FILL_LO]
    };

    // Range decode uses the configuration just written alongside the invalidate bit.
    always @* begin
        inv_go = wr_ok & ctl_wr_data[`CC_INV_ALL_BIT];
        inv_none = 1'b0;
        inv_first = {IDX_W{1'b0}};
        inv_last = full_last_w[IDX_W-1:0];
        if (new_split) begin
            case ({ctl_wr_data[`CC_INV_INSTR_BIT], ctl_wr_data[`CC_INV_DATA_BIT]})
                2'h1: begin
                    inv_last = half_last_w[IDX_W-1:0];
                end
                2'h2: begin
                    inv_first = half_first_w[IDX_W-1:0];
                end
                2'h3: begin
                    inv_none = 1'b1;
                end
                default: begin
                    inv_first = {IDX_W{1'b0}};
                end
            endcase
        end
    end

    // Invalidate engine: a few overhead cycles, then one tag entry per cycle.
    always @* begin
        state_next = state_reg;
        idx_next = tag_clr_idx_reg;
        last_next = last_reg;
        ovh_next = ovh_reg;
        clr_next = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (inv_go && !inv_none) begin
                    state_next = ST_OVH;
                    idx_next = inv_first;
                    last_next = inv_last;
                    ovh_next = ovh_init_w[IDX_W:0];
                end
            end
            ST_OVH: begin
                if (ovh_reg == {(IDX_W+1){1'b0}}) begin
                    state_next = ST_CLR;
                    clr_next = 1'b1;
                end else begin
                    ovh_next = ovh_reg - 1'b1;
                end
            end
            ST_CLR: begin
                if (tag_clr_idx_reg == last_reg) begin
                    state_next = ST_IDLE;
                end else begin
                    idx_next = tag_clr_idx_reg + 1'b1;
                    clr_next = 1'b1;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    assign inv_busy = (state_reg != ST_IDLE);

    // Configuration decode.
    assign cfg_array_on = ctl_reg[`CC_ENB_BIT];
    // Enable plus the two disable bits pick split, instruction-only or data-only use of the array.
    reg split_c;
    reg instr_c;
    reg data_c;

    always @* begin
        split_c = 1'b0;
        instr_c = 1'b0;
        data_c = 1'b0;
        case ({cfg_array_on, instr_off, data_off})
            3'h4: begin
                split_c = 1'b1;
                instr_c = 1'b1;
                data_c = 1'b1;
            end
            3'h5: begin
                instr_c = 1'b1;
            end
            3'h6: begin
                data_c = 1'b1;
            end
            3'h7: begin
                // Both kinds disabled: the array is on but caches nothing.
                split_c = 1'b0;
            end
            default: begin
                split_c = 1'b0;
            end
        endcase
    end

    assign cfg_split = split_c;
    assign cfg_instr_cache = instr_c;
    assign cfg_data_cache = data_c;

    // Default attribute applies only when no mapped space covers the access.
    assign acc_cacheable = acc_default_attr ? ~ctl_reg[`CC_DEF_CACHE_OFF_BIT] : acc_map_cacheable;

    assign fill_burst = fill_noncacheable & ctl_reg[`CC_NC_BURST_BIT];
    assign fill_size = ctl_reg[`CC_FILL_HI:`CC_FILL_LO];
    // Line-fill buffer contents from non-cacheable fetches stay out of the array.
    assign array_write_en = lfb_write_req & ~lfb_noncacheable & cfg_array_on;

    // Write policy: buffered writes end on the local bus at once.
    assign bc_wr_push = lb_wr_req;
    assign bc_wr_buffered = ctl_reg[`CC_DEF_WBUF_BIT];
    assign lb_wr_term = bc_wr_buffered ? lb_wr_req : (wait_reg & ext_wr_done);

    always @* begin
        wait_next = wait_reg;
        if (wait_reg && ext_wr_done) begin
            wait_next = 1'b0;
        end
        if (lb_wr_req && !bc_wr_buffered) begin
            wait_next = 1'b1;
        end
    end

    // Control register storage.
    always @(posedge mclk) begin
        if (!rst_n) begin
            ctl_reg <= `CC_RESET_VALUE;
        end else begin
            ctl_reg <= ctl_next;
        end
    end

    // Invalidate engine; index and strobe leave straight from flip-flops.
    always @(posedge mclk) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            tag_clr_idx_reg <= {IDX_W{1'b0}};
            tag_clr_en_reg <= 1'b0;
            last_reg <= {IDX_W{1'b0}};
            ovh_reg <= {(IDX_W+1){1'b0}};
        end else begin
            state_reg <= state_next;
            tag_clr_idx_reg <= idx_next;
            tag_clr_en_reg <= clr_next;
            last_reg <= last_next;
            ovh_reg <= ovh_next;
        end
    end

    // Unbuffered write waiting for its external completion.
    always @(posedge mclk) begin
        if (!rst_n) begin
            wait_reg <= 1'b0;
        end else begin
            wait_reg <= wait_next;
        end
    end

    // The error is flagged when the external cycle fails, detached from the instruction.
    always @(posedge mclk) begin
        if (!rst_n) begin
            wr_access_err_reg <= 1'b0;
        end else begin
            wr_access_err_reg <= ext_wr_err;
        end
    end

endmodule
`default_nettype wire

/* dv/cc_bus_model.sv */
// Bus controller stand-in that completes only the latest pushed external write after a set latency.
`timescale 1ns/1ps
`default_nettype none
module cc_bus_model (
    input wire logic mclk,
    input wire logic bc_wr_push,
    input wire logic [3:0] lat,
    input wire logic err_en,
    output logic ext_wr_done,
    output logic ext_wr_err
);
    int cnt = 0;
    initial {ext_wr_done, ext_wr_err} = 2'h0;
    // Completion lands lat cycles after the push, so the local write is never ended early.
    always @(posedge mclk) begin
        ext_wr_done <= (cnt == 1);
        ext_wr_err <= (cnt == 1) && err_en;
        cnt <= bc_wr_push ? int'(lat) : (cnt > 0 ? cnt - 1 : 0);
    end
endmodule
`default_nettype wire

/* dv/cc_ctrl_chk.sv */
// Port-level assertions for the cache control register block.
`timescale 1ns/1ps
`default_nettype none
module cc_ctrl_chk #(parameter IDX_W = 9) (
    input wire logic mclk, rst_n, ctl_wr_en, ctl_supervisor, inv_busy, tag_clr_en_reg,
    input wire logic [31:0] ctl_wr_data, ctl_rd_data,
    input wire logic [IDX_W-1:0] tag_clr_idx_reg,
    input wire logic fill_noncacheable, fill_burst, lfb_write_req, lfb_noncacheable, array_write_en,
    input wire logic acc_default_attr, acc_cacheable, lb_wr_req, lb_wr_term, bc_wr_buffered,
    input wire logic ext_wr_done, ext_wr_err, wr_access_err_reg
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    wire wr = ctl_wr_en && ctl_supervisor;
    wire [31:0] d = ctl_wr_data;
    inv_reads_zero_a: assert property (ctl_rd_data[24] == 1'b0) else $error("bit 24 read as one");
    half_gate_a: assert property (wr && (d[23] || d[22]) |=> ctl_rd_data[21:20] == 2'h0)
        else $error("half invalidate bits kept");
    inv_start_a: assert property (wr && d[24] && !inv_busy && d[23:20] != 4'h3
        |=> inv_busy [*3] ##1 tag_clr_en_reg) else $error("clearing late");
    clr_step_a: assert property (tag_clr_en_reg && $past(tag_clr_en_reg)
        |-> tag_clr_idx_reg == $past(tag_clr_idx_reg) + 1'b1) else $error("index skipped");
    nc_burst_a: assert property (fill_burst == (fill_noncacheable && ctl_rd_data[10])) else $error("burst");
    nc_array_a: assert property (lfb_write_req && lfb_noncacheable |-> !array_write_en) else $error("nc");
    def_attr_a: assert property (acc_default_attr |-> acc_cacheable == !ctl_rd_data[9]) else $error("attr");
    buf_term_a: assert property (lb_wr_req && bc_wr_buffered |-> lb_wr_term) else $error("late end");
    unbuf_term_a: assert property (lb_wr_term && !bc_wr_buffered |-> ext_wr_done) else $error("early");
    err_late_a: assert property (ext_wr_err |=> wr_access_err_reg) else $error("error lost");
endmodule
bind cc_ctrl cc_ctrl_chk #(.IDX_W(IDX_W)) cc_ctrl_chk_i (.*);
`default_nettype wire

/* dv/testbench.sv */
// Self-checking bench for the cache control register block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
    logic mclk = 0, rst_n = 0, wr_en = 0, sup = 1, lb_wr_req = 0, err_en = 0;
    logic [31:0] wr_data = 32'h0;
    logic [4:0] misc = 5'h00;
    wire [31:0] rd;
    wire [8:0] idx;
    wire clr_en, busy, term, buffered, done, err, err_reg, push;
    int fail_count = 0, tests_run = 0, n, first;
    // Row: supervisor flag, written word, expected readback.
    logic [64:0] rows [4] = '{{1'b1, 32'hFFF007FF, 32'h80C00703}, {1'b1, 32'h00300102, 32'h00300102},
        {1'b0, 32'h80000000, 32'h00300102}, {1'b1, 32'h80700601, 32'h80400601}};
    logic [31:0] md [6] = '{32'h01000000, 32'h01100000, 32'h01200000, 32'h01300000, 32'h01800000, 32'h81400000};
    int mn [6] = '{16, 8, 8, 0, 16, 16};
    int mf [6] = '{0, 0, 8, -1, 0, 0};
    wire cfg_on, cfg_sp, cfg_ic, cfg_dc, acc, burst, awe;
    wire [1:0] fsize;
    wire [8:0] cfg_out = {cfg_on, cfg_sp, cfg_ic, cfg_dc, acc, burst, fsize, awe};
    // Row: written word, side inputs, expected {on, split, instr, data, cacheable, burst, size, array write}.
    logic [45:0] cr [4] = '{{32'h80000402, 5'h0D, 9'h1FD}, {32'h80800201, 5'h19, 9'h122},
        {32'h00400300, 5'h0A, 9'h010}, {32'h80400400, 5'h04, 9'h148}};
    cc_ctrl #(.TAG_ENTRIES(16), .TAG_HALF(8)) cc_ctrl_i (.mclk(mclk), .rst_n(rst_n), .ctl_wr_en(wr_en),
        .ctl_supervisor(sup), .ctl_wr_data(wr_data), .ctl_rd_data(rd), .tag_clr_en_reg(clr_en),
        .tag_clr_idx_reg(idx), .inv_busy(busy), .cfg_array_on(cfg_on), .cfg_split(cfg_sp),
        .cfg_instr_cache(cfg_ic), .cfg_data_cache(cfg_dc), .acc_default_attr(misc[0]),
        .acc_map_cacheable(misc[1]), .acc_cacheable(acc), .fill_noncacheable(misc[2]), .fill_burst(burst),
        .fill_size(fsize), .lfb_write_req(misc[3]), .lfb_noncacheable(misc[4]), .array_write_en(awe),
        .lb_wr_req(lb_wr_req), .lb_wr_term(term),
        .bc_wr_push(push), .bc_wr_buffered(buffered), .ext_wr_done(done), .ext_wr_err(err),
        .wr_access_err_reg(err_reg));
    cc_bus_model cc_bus_model_i (.mclk(mclk), .bc_wr_push(push), .lat(4'h3), .err_en(err_en),
        .ext_wr_done(done), .ext_wr_err(err));
    initial forever #20 mclk = ~mclk;
    task automatic wrap_up;
        $display("checks=%0d failures=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wr(input logic s, input logic [31:0] dat);
        sup = s;
        wr_data = dat;
        wr_en = 1;
        @(negedge mclk) wr_en = 0;
    endtask
    initial begin
        repeat (1500) @(posedge mclk);
        fail_count++;
        wrap_up;
    end
    initial begin
        repeat (16) @(negedge mclk);
        rst_n = 1;
        `CHK(rd, 32'h0)
        // Every mode is swept; the last write of the sweep also enables the array.
        for (int m = 0; m < 6; m++) begin
            n = 0;
            first = -1;
            wr(1, md[m]);
            repeat (24) begin
                if (clr_en === 1'b1 && first < 0) first = idx;
                n += (clr_en === 1'b1);
                @(negedge mclk);
            end
            `CHK(n, mn[m])
            `CHK(first, mf[m])
            `CHK(busy, 1'b0)
        end
        foreach (rows[i]) begin
            misc = 5'(i * 13);
            wr(rows[i][64], rows[i][63:32]);
            `CHK(rd, rows[i][31:0])
        end
        foreach (cr[i]) begin
            misc = cr[i][13:9];
            wr(1, cr[i][45:14]);
            `CHK(cfg_out, cr[i][8:0])
        end
        wr(1, 32'h00000100);
        lb_wr_req = 1;
        #1 `CHK(term, 1'b1)
        `CHK(buffered, 1'b1)
        @(negedge mclk) lb_wr_req = 0;
        wr(1, 32'h0);
        `CHK(buffered, 1'b0)
        err_en = 1;
        lb_wr_req = 1;
        #1 `CHK(term, 1'b0)
        @(negedge mclk) lb_wr_req = 0;
        n = 0;
        while (term !== 1'b1 && n < 20) begin
            @(negedge mclk);
            n++;
        end
        `CHK(n, 3)
        @(negedge mclk) `CHK(err_reg, 1'b1)
        wr(1, 32'h80000703);
        `CHK(rd, 32'h80000703)
        rst_n = 0;
        @(negedge mclk) rst_n = 1;
        `CHK(rd, 32'h0)
        wrap_up;
    end
endmodule
`default_nettype wire
